// File: hw/trg_pkg.sv
// constants and types for the hidden timekeeper enable gate
// assumes a single 125 MHz clock domain and synchronous host strobes
package trg_pkg;
    localparam int          PAT_BITS    = 64;
    localparam int          XFER_BITS   = 64;
    localparam logic [63:0] UNLOCK_PAT  = 64'h5ca3_3ac5_5ca3_3ac5;
    localparam int          CLK_MHZ     = 125;
    localparam int          TICK_HZ     = 100;
    localparam int          TICK_CYC    = CLK_MHZ * 1000000 / TICK_HZ;
    localparam int          SEC_B       = 8;
    localparam int          MIN_B       = 16;
    localparam int          HR_B        = 24;
    localparam int          DOW_B       = 32;
    localparam int          DATE_B      = 40;
    localparam int          MON_B       = 48;
    localparam int          YR_B        = 56;
    localparam int          HR_MODE_BIT = 31;
    localparam int          HR_PM_BIT   = 29;
    localparam logic [63:0] TIME_RST    = 64'h0001_0101_9200_0000;

    typedef enum logic [2:0]
    {
        TRG_MATCH = 3'b001,
        TRG_DEAD  = 3'b010,
        TRG_XFER  = 3'b100
    } trg_state_e;

    typedef struct packed
    {
        logic sel_b;
        logic oe_b;
        logic we_b;
        logic lsb;
    } trg_bus_s;
endpackage

// File: hw/trg_gate.sv
// hidden timekeeper gate between host bytewide bus and memory
// assumes host strobes are synchronous to ref_clk, memory type strap is static
`timescale 1ns/1ps
module trg_gate
#(
    parameter int TICK_CYC = trg_pkg::TICK_CYC
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire trg_pkg::trg_bus_s host_bus,
    input  wire logic             rom_mode,
    input  wire logic             power_fail,
    output logic                  memory_select_out_b,
    output logic                  lsb_data_line_o,
    output logic                  lsb_data_line_oe,
    output logic                  clock_open
);
    trg_pkg::trg_state_e st_r, st_nxt;
    logic [6:0]  ptr_r, ptr_nxt;
    logic        sel_d_r, sel_d_nxt;
    logic        wr_d_r, wr_d_nxt;
    logic        lsb_d_r, lsb_d_nxt;
    logic [63:0] tm_r, tm_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic        cs_r, cs_nxt;
    logic        dq_r, dq_nxt;
    logic        dqe_r, dqe_nxt;
    logic        open_r, open_nxt;
    logic        strobe_end;
    logic        is_read;

    // bit offsets of the time fields, local copies of the package values
    localparam int SEC_B       = trg_pkg::SEC_B;
    localparam int MIN_B       = trg_pkg::MIN_B;
    localparam int HR_B        = trg_pkg::HR_B;
    localparam int DOW_B       = trg_pkg::DOW_B;
    localparam int DATE_B      = trg_pkg::DATE_B;
    localparam int MON_B       = trg_pkg::MON_B;
    localparam int YR_B        = trg_pkg::YR_B;
    localparam int HR_MODE_BIT = trg_pkg::HR_MODE_BIT;

    // bcd increment with carry from units into tens, no wrap; callers wrap at top values
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // last date of the month in bcd
    function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        // even tens with units 0/4/8, or odd tens with units 2/6, is a multiple of four
        leap = ({yr[4], yr[1:0]} == 3'b000) || ({yr[4], yr[1:0]} == 3'b110);
        case (mon)
            8'h02:   month_end = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    endfunction

    // one step of the calendar on each hundredth tick
    function automatic logic [63:0] advance(input logic [63:0] t);
        logic [63:0] n;
        logic        carry;
        logic [7:0]  h;
        logic [7:0]  s;
        n = t;
        carry = 1'b0;
        n[7:0] = (t[7:0] == 8'h99) ? 8'h00 : bcd_inc(t[7:0]);
        if (t[7:0] == 8'h99)
        begin
            n[SEC_B+:8] = (t[SEC_B+:8] == 8'h59) ? 8'h00 : bcd_inc(t[SEC_B+:8]);
            carry = (t[SEC_B+:8] == 8'h59);
        end
        if (carry)
        begin
            n[MIN_B+:8] = (t[MIN_B+:8] == 8'h59) ? 8'h00 : bcd_inc(t[MIN_B+:8]);
            carry = (t[MIN_B+:8] == 8'h59);
        end
        if (carry)
        begin
            h = t[HR_B+:8];
            carry = 1'b0;
            if (h[HR_MODE_BIT-HR_B])
            begin
                if (h[4:0] == 5'h12)
                    n[HR_B+:8] = {h[7:5], 5'h01};
                else if (h[4:0] == 5'h11)
                begin
                    n[HR_B+:8] = {h[7:6], ~h[5], 5'h12};
                    carry = h[5];
                end
                else
                begin
                    s = bcd_inc({3'h0, h[4:0]});
                    n[HR_B+:8] = {h[7:5], s[4:0]};
                end
            end
            else
            begin
                carry = (h[5:0] == 6'h23);
                s = bcd_inc({2'h0, h[5:0]});
                n[HR_B+:8] = carry ? {h[7:6], 6'h00} : {h[7:6], s[5:0]};
            end
        end
        if (carry)
        begin
            n[DOW_B+:8] = (t[DOW_B+:8] == 8'h07) ? 8'h01 : bcd_inc(t[DOW_B+:8]);
            n[DATE_B+:8] = bcd_inc(t[DATE_B+:8]);
            carry = (t[DATE_B+:8] == month_end(t[MON_B+:8], t[YR_B+:8]));
            if (carry)
            begin
                n[DATE_B+:8] = 8'h01;
                n[MON_B+:8] = (t[MON_B+:8] == 8'h12) ? 8'h01 : bcd_inc(t[MON_B+:8]);
                if (t[MON_B+:8] == 8'h12)
                    n[YR_B+:8] = (t[YR_B+:8] == 8'h99) ? 8'h00 : bcd_inc(t[YR_B+:8]);
            end
        end
        advance = n;
    endfunction

    // cycle end: select released after being low, outside power fail
    assign strobe_end = sel_d_r && host_bus.sel_b && !power_fail;
    assign is_read    = !wr_d_r;

    // recognition, transfer and timekeeping next values
    always_comb
    begin
        st_nxt    = st_r;
        ptr_nxt   = ptr_r;
        tm_nxt    = tm_r;
        tick_nxt  = tick_r + 32'h1;
        sel_d_nxt = !host_bus.sel_b;
        wr_d_nxt  = sel_d_r ? wr_d_r : !host_bus.we_b;
        lsb_d_nxt = host_bus.lsb;
        if (!host_bus.sel_b && !host_bus.we_b)
            wr_d_nxt = 1'b1;
        if (!host_bus.sel_b && !host_bus.oe_b && host_bus.we_b)
            wr_d_nxt = 1'b0;
        if (tick_r == TICK_CYC - 1)
        begin
            tick_nxt = 32'h0;
            tm_nxt = advance(tm_r);
        end
        if (power_fail)
        begin
            st_nxt  = trg_pkg::TRG_MATCH;
            ptr_nxt = 7'h0;
        end
        else if (strobe_end)
        begin
            case (st_r)
                trg_pkg::TRG_MATCH, trg_pkg::TRG_DEAD:
                begin
                    if (is_read)
                    begin
                        st_nxt  = trg_pkg::TRG_MATCH;
                        ptr_nxt = 7'h0;
                    end
                    else if (st_r == trg_pkg::TRG_MATCH)
                    begin
                        if (lsb_d_r == trg_pkg::UNLOCK_PAT[ptr_r[5:0]])
                        begin
                            ptr_nxt = ptr_r + 7'h1;
                            if (ptr_r == 7'(trg_pkg::PAT_BITS - 1))
                            begin
                                st_nxt  = trg_pkg::TRG_XFER;
                                ptr_nxt = 7'h0;
                            end
                        end
                        else
                            st_nxt = trg_pkg::TRG_DEAD;
                    end
                end
                trg_pkg::TRG_XFER:
                begin
                    if (!is_read)
                        tm_nxt[ptr_r[5:0]] = lsb_d_r;
                    ptr_nxt = ptr_r + 7'h1;
                    if (ptr_r == 7'(trg_pkg::XFER_BITS - 1))
                    begin
                        st_nxt  = trg_pkg::TRG_MATCH;
                        ptr_nxt = 7'h0;
                    end
                end
                default:
                begin
                    st_nxt  = trg_pkg::TRG_MATCH;
                    ptr_nxt = 7'h0;
                end
            endcase
        end
    end

    // memory select and read data drive
    always_comb
    begin
        open_nxt = (st_nxt == trg_pkg::TRG_XFER);
        dq_nxt   = tm_nxt[ptr_nxt[5:0]];
        dqe_nxt  = (st_nxt == trg_pkg::TRG_XFER) && !host_bus.sel_b && !host_bus.oe_b
                   && !power_fail;
        if (power_fail)
            cs_nxt = rom_mode ? 1'b0 : 1'b1;
        else if (st_nxt == trg_pkg::TRG_XFER)
            cs_nxt = 1'b1;
        else
            cs_nxt = host_bus.sel_b;
    end

    // state registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            st_r    <= trg_pkg::TRG_MATCH;
            ptr_r   <= 7'h0;
            sel_d_r <= 1'b0;
            wr_d_r  <= 1'b0;
            lsb_d_r <= 1'b0;
            tm_r    <= trg_pkg::TIME_RST;
            tick_r  <= 32'h0;
            cs_r    <= 1'b1;
            dq_r    <= 1'b0;
            dqe_r   <= 1'b0;
            open_r  <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            ptr_r   <= ptr_nxt;
            sel_d_r <= sel_d_nxt;
            wr_d_r  <= wr_d_nxt;
            lsb_d_r <= lsb_d_nxt;
            tm_r    <= tm_nxt;
            tick_r  <= tick_nxt;
            cs_r    <= cs_nxt;
            dq_r    <= dq_nxt;
            dqe_r   <= dqe_nxt;
            open_r  <= open_nxt;
        end
    end

    assign memory_select_out_b = cs_r;
    assign lsb_data_line_o     = dq_r;
    assign lsb_data_line_oe    = dqe_r;
    assign clock_open          = open_r;
endmodule

// File: tb/trg_gate_props.sv
// port checker for the timekeeper enable gate
// assumes binding onto trg_gate, one clock domain, synchronous active-low reset
`timescale 1ns/1ps
module trg_gate_props
(
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire trg_pkg::trg_bus_s host_bus,
    input wire logic              rom_mode,
    input wire logic              power_fail,
    input wire logic              memory_select_out_b,
    input wire logic              lsb_data_line_o,
    input wire logic              lsb_data_line_oe,
    input wire logic              clock_open
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // memory select relations
    property p_pass;
        !power_fail && !clock_open |=> memory_select_out_b == $past(host_bus.sel_b);
    endproperty
    a_pass: assert property (p_pass) else $error("select not following host");
    property p_ram_fail;
        power_fail && !rom_mode |=> memory_select_out_b;
    endproperty
    a_ram_fail: assert property (p_ram_fail) else $error("memory open in fail");
    property p_rom_fail;
        power_fail && rom_mode |=> !memory_select_out_b;
    endproperty
    a_rom_fail: assert property (p_rom_fail) else $error("rom not selected in fail");
    property p_hold;
        clock_open && !power_fail |=> memory_select_out_b;
    endproperty
    a_hold: assert property (p_hold) else $error("memory selected in transfer");
    // clock access phase relations
    property p_fail_close;
        power_fail |=> !clock_open;
    endproperty
    a_fail_close: assert property (p_fail_close) else $error("open during fail");
    property p_reset;
        disable iff (1'b0) !rst_b |=> memory_select_out_b && !clock_open && !lsb_data_line_oe;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset outputs");
    property p_oe;
        lsb_data_line_oe |-> $past(clock_open);
    endproperty
    a_oe: assert property (p_oe) else $error("data driven outside transfer");
    property p_oe_rd;
        host_bus.oe_b |=> !lsb_data_line_oe;
    endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("data driven without read");
    property p_open;
        $rose(clock_open) |-> !$past(power_fail) && $past(host_bus.sel_b);
    endproperty
    a_open: assert property (p_open) else $error("opened off a cycle end");
    c_open: cover property ($rose(clock_open));
    c_close: cover property ($fell(clock_open) && !power_fail);
    c_rom_fail: cover property (power_fail && rom_mode);
endmodule
bind trg_gate trg_gate_props u_props (.ref_clk(ref_clk), .rst_b(rst_b), .host_bus(host_bus),
    .rom_mode(rom_mode), .power_fail(power_fail), .memory_select_out_b(memory_select_out_b),
    .lsb_data_line_o(lsb_data_line_o), .lsb_data_line_oe(lsb_data_line_oe),
    .clock_open(clock_open));

// File: tb/trg_sram_model.sv
// memory stand-in holding data bit 0 of one scratch location
// assumes it is selected only by the gate's memory select output
`timescale 1ns/1ps
module trg_sram_model
(
    input  wire logic              ref_clk,
    input  wire logic              mem_sel_b,
    input  wire trg_pkg::trg_bus_s host_bus,
    output logic                   rd_bit,
    output int                     hits
);
    logic cell_r = 1'b0;
    logic last_r = 1'b0;
    int   hit_cnt = 0;
    assign hits = hit_cnt;
    // store selected writes, count selected edges, remember last line level
    always @(posedge ref_clk)
    begin
        if (!mem_sel_b)
            hit_cnt <= hit_cnt + 1;
        if (!mem_sel_b && !host_bus.we_b)
            cell_r <= host_bus.lsb;
        last_r <= rd_bit;
    end
    // released line shows the inverse of its last level
    assign rd_bit = (!mem_sel_b && !host_bus.oe_b) ? cell_r : ~last_r;
endmodule

// File: tb/transparent_rtc_enable_gate_tb_top.sv
// self-checking bench for the timekeeper enable gate
// assumes a hundredth tick every 1000 clocks; each time read ends inside one tick period
`timescale 1ns/1ps
module transparent_rtc_enable_gate_tb_top;
    logic              ref_clk;
    logic              rst_b;
    trg_pkg::trg_bus_s host_bus;
    logic              rom_mode;
    logic              power_fail;
    logic              memory_select_out_b;
    logic              lsb_data_line_o;
    logic              lsb_data_line_oe;
    logic              clock_open;
    logic              mem_bit;
    int                hits;
    int                miscompares;
    int                checks_done;
    logic [63:0]       got;

    trg_gate #(.TICK_CYC(1000)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .host_bus(host_bus),
        .rom_mode(rom_mode), .power_fail(power_fail), .memory_select_out_b(memory_select_out_b),
        .lsb_data_line_o(lsb_data_line_o), .lsb_data_line_oe(lsb_data_line_oe),
        .clock_open(clock_open));
    trg_sram_model u_sram (.ref_clk(ref_clk), .mem_sel_b(memory_select_out_b),
        .host_bus(host_bus), .rd_bit(mem_bit), .hits(hits));

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one host strobe held low three cycles, data and select taken before release
    task automatic cyc(input logic wr, input logic b, output logic rd, output logic ms);
        @(negedge ref_clk);
        host_bus = '{sel_b: 1'b0, oe_b: wr, we_b: !wr, lsb: b};
        repeat (3) @(negedge ref_clk);
        rd = lsb_data_line_oe ? lsb_data_line_o : mem_bit;
        ms = memory_select_out_b;
        host_bus = '{sel_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, lsb: ~b};
        @(negedge ref_clk);
    endtask

    task automatic unlock();
        logic r;
        logic m;
        cyc(1'b0, 1'b0, r, m);
        for (int i = 0; i < trg_pkg::PAT_BITS; i++)
            cyc(1'b1, trg_pkg::UNLOCK_PAT[i], r, m);
    endtask

    task automatic s_pass();
        logic r;
        logic m;
        cyc(1'b1, 1'b1, r, m);
        chk("pass select", 64'h0, 64'(m));
        cyc(1'b0, 1'b0, r, m);
        chk("pass data", 64'h1, 64'(r));
    endtask

    task automatic s_open();
        logic m;
        logic all_ms;
        int   h;
        unlock();
        chk("open", 64'h1, 64'(clock_open));
        all_ms = 1'b1;
        h = hits;
        for (int i = 0; i < trg_pkg::XFER_BITS; i++)
        begin
            cyc(1'b0, 1'b0, got[i], m);
            all_ms &= m;
        end
        chk("time bits", trg_pkg::TIME_RST, got);
        chk("memory idle", 64'(h), 64'(hits));
        chk("select held", 64'h1, 64'(all_ms));
        chk("closed", 64'h0, 64'(clock_open));
    endtask

    // a wrong bit, then a read in mid-pattern, must both keep the clock hidden
    task automatic s_broken();
        logic r;
        logic m;
        for (int k = 0; k < 2; k++)
        begin
            cyc(1'b0, 1'b0, r, m);
            for (int i = 0; i < trg_pkg::PAT_BITS; i++)
            begin
                if (k == 1 && i == 20)
                    cyc(1'b0, 1'b0, r, m);
                cyc(1'b1, trg_pkg::UNLOCK_PAT[i] ^ (k == 0 && i == 5), r, m);
            end
            chk("not open", 64'h0, 64'(clock_open));
        end
    endtask

    task automatic s_fail(input logic exp_ms);
        logic r;
        logic m;
        unlock();
        power_fail = 1'b1;
        cyc(1'b0, 1'b0, r, m);
        chk("fail select", 64'(exp_ms), 64'(m));
        chk("fail close", 64'h0, 64'(clock_open));
        power_fail = 1'b0;
    endtask

    // fresh reset, set 11:59:59.99 pm on 28 feb of a leap year, let one tick pass, read back;
    // writing ends near clock 645, the tick falls at 1000, reading spans 1045 to 1690
    task automatic s_cal();
        logic        r;
        logic        m;
        logic [63:0] set_t = 64'h1202_2807_b159_5999;
        rst_b = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        unlock();
        for (int i = 0; i < trg_pkg::XFER_BITS; i++)
            cyc(1'b1, set_t[i], r, m);
        repeat (400) @(negedge ref_clk);
        unlock();
        for (int i = 0; i < trg_pkg::XFER_BITS; i++)
            cyc(1'b0, 1'b0, got[i], m);
        chk("calendar step", 64'h1202_2901_9200_0000, got);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // cut a hang short
    initial
    begin
        repeat (50000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end

    // main sequence: RAM mode, a second reset into ROM mode, a third for the calendar
    initial
    begin
        host_bus = '{sel_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, lsb: 1'b0};
        rom_mode = 1'b0;
        power_fail = 1'b0;
        rst_b = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        chk("reset select", 64'h1, 64'(memory_select_out_b));
        s_pass();
        s_open();
        s_broken();
        s_fail(1'b1);
        rst_b = 1'b0;
        rom_mode = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        s_pass();
        s_open();
        s_fail(1'b0);
        s_cal();
        wrap_up();
    end
endmodule
